// ===== logic/serial_mem_device.sv
`timescale 1ns/1ps
module serial_mem_device
	import serial_mem_pkg::*;
(
	spi_link_if.dev link,
	input wire logic porRst,
	output logic clkMode3,
	output logic selected,
	output logic [7:0] statusWord
);

	typedef struct packed {
		phase_e phase;
		logic [2:0] bitCnt;
		logic [6:0] shIn;
		logic [ADDR_W-1:0] addr;
		logic addrLo;
		logic isRead;
		logic [7:0] rdByte;
	} frame_s;

	typedef struct packed {
		logic wel;
		logic [7:0] status;
	} persist_s;

	typedef struct packed {
		logic soBit;
		logic soEn;
	} out_s;

	frame_s fr_r;
	frame_s fr_nxt;
	persist_s ps_r;
	persist_s ps_nxt;
	out_s out_r;
	out_s out_nxt;
	logic mode3_r;
	logic [7:0] mem [MEM_DEPTH];
	logic memWe;
	logic [ADDR_W-1:0] memWrAddr;
	logic [7:0] memWrData;
	logic frameRst;
	logic [7:0] rxByte;
	logic byteDone;
	logic stWriteOk;
	logic wpSync1_r;
	logic wpSync2_r;

	// address arithmetic wraps at the top, so the array must match it exactly
	if (MEM_DEPTH != (1 << ADDR_W) || BYTE_W != 8) begin : g_bad_geometry
		$error("array depth does not match the address width");
	end

	// a select rise while held is not acted on until hold lifts
	assign frameRst = link.csN & link.holdN;

	assign rxByte = {fr_r.shIn, link.mosi};
	assign byteDone = (fr_r.bitCnt == LAST_BIT);
	assign stWriteOk = ps_r.wel & ~(ps_r.status[ST_PROTECT_BIT] & ~wpSync2_r);

	always_comb begin
		fr_nxt = fr_r;
		ps_nxt = ps_r;
		memWe = 1'b0;
		memWrAddr = fr_r.addr;
		memWrData = rxByte;
		if (link.holdN) begin
			fr_nxt.bitCnt = fr_r.bitCnt + 3'h1;
			fr_nxt.shIn = rxByte[6:0];
			if (byteDone) begin
				case (fr_r.phase)
					PH_OPCODE: begin
						case (rxByte)
							OPC_WREN: begin
								ps_nxt.wel = 1'b1;
								fr_nxt.phase = PH_IGNORE;
							end
							OPC_WRDI: begin
								ps_nxt.wel = 1'b0;
								fr_nxt.phase = PH_IGNORE;
							end
							OPC_RDSR: begin
								fr_nxt.rdByte = ps_r.status;
								fr_nxt.phase = PH_ST_RD;
							end
							OPC_WRSR: begin
								fr_nxt.phase = PH_ST_WR;
							end
							OPC_READ: begin
								fr_nxt.isRead = 1'b1;
								fr_nxt.phase = PH_ADDR;
							end
							OPC_WRITE: begin
								fr_nxt.isRead = 1'b0;
								fr_nxt.phase = PH_ADDR;
							end
							default: begin
								fr_nxt.phase = PH_IGNORE;
							end
						endcase
					end
					PH_ADDR: begin
						if (!fr_r.addrLo) begin
							fr_nxt.addr = {rxByte, fr_r.addr[7:0]};
							fr_nxt.addrLo = 1'b1;
						end else if (fr_r.isRead) begin
							fr_nxt.rdByte = mem[{fr_r.addr[15:8], rxByte}];
							fr_nxt.addr = {fr_r.addr[15:8], rxByte} + 16'h0001;
							fr_nxt.phase = PH_MEM_RD;
						end else begin
							fr_nxt.addr = {fr_r.addr[15:8], rxByte};
							fr_nxt.phase = PH_MEM_WR;
						end
					end
					PH_MEM_WR: begin
						// the byte lands on the edge that completes it
						memWe = ps_r.wel;
						fr_nxt.addr = fr_r.addr + 16'h0001;
					end
					PH_MEM_RD: begin
						fr_nxt.rdByte = mem[fr_r.addr];
						fr_nxt.addr = fr_r.addr + 16'h0001;
					end
					PH_ST_RD: begin
						fr_nxt.rdByte = ps_r.status;
					end
					PH_ST_WR: begin
						if (stWriteOk) begin
							ps_nxt.status = (ps_r.status & ~ST_WRITABLE_MASK) |
								(rxByte & ST_WRITABLE_MASK);
						end
						fr_nxt.phase = PH_IGNORE;
					end
					PH_IGNORE: begin
						fr_nxt.phase = PH_IGNORE;
					end
					default: begin
						fr_nxt.phase = PH_IGNORE;
					end
				endcase
			end
		end
	end

	// sequence state lives only while selected or held
	always_ff @(posedge link.sck or posedge frameRst) begin
		if (frameRst) begin
			fr_r <= '{phase: PH_OPCODE, bitCnt: 3'h0, shIn: 7'h00, addr: 16'h0000,
				addrLo: 1'b0, isRead: 1'b0, rdByte: 8'h00};
		end else begin
			fr_r <= fr_nxt;
		end
	end

	// latches survive deselect; only power-on clears them
	always_ff @(posedge link.sck or posedge porRst) begin
		if (porRst) begin
			ps_r <= '{wel: 1'b0, status: ST_RESET};
		end else if (!link.csN) begin
			ps_r <= ps_nxt;
		end
	end

	// the protect pin is asynchronous to the link clock; two stages settle it
	// within the opcode byte, long before any status data bit arrives
	always_ff @(posedge link.sck) begin
		wpSync1_r <= link.wpN;
		wpSync2_r <= wpSync1_r;
	end

	// no reset on the array: contents persist across deselect and power-on clear
	always_ff @(posedge link.sck) begin
		if (memWe && !link.csN) begin
			mem[memWrAddr] <= memWrData;
		end
	end

	always_comb begin
		out_nxt = out_r;
		// held, the pending bit and enable stay put, so resuming skips nothing
		if (link.holdN) begin
			out_nxt.soBit = fr_r.rdByte[~fr_r.bitCnt];
			out_nxt.soEn = (fr_r.phase == PH_MEM_RD) || (fr_r.phase == PH_ST_RD);
		end
	end

	// read data moves only on falling edges, after the first rising edge
	always_ff @(negedge link.sck or posedge frameRst) begin
		if (frameRst) begin
			out_r <= '{soBit: 1'b0, soEn: 1'b0};
		end else begin
			out_r <= out_nxt;
		end
	end

	// mode is the clock level seen when select falls
	always_ff @(negedge link.csN) begin
		mode3_r <= link.sck;
	end

	assign link.misoOut = out_r.soBit;
	assign link.misoOe = out_r.soEn & ~link.csN & link.holdN;
	assign clkMode3 = mode3_r;
	assign selected = ~link.csN;
	assign statusWord = ps_r.status;

endmodule

// ===== logic/serial_mem_pkg.sv
// Contract
// - deselected device idles, ignores inputs, output tristated
// - master lowers select before every opcode
// - inputs sampled rising edge, outputs change falling
// - any link clock up to 40 MHz, stoppable
// - serial input looked at only on rising edges
// - output driven only for read data, never held
// - protect bit and low protect pin block status write
// - hold low freezes operation, state kept
// - during hold ignore clock and select changes
// - master changes hold only while clock low
// - 64K bytes, 16-bit address as two bytes
// - each write finishes within its own transfer
// - first byte after select is the opcode
// - all bytes travel most significant bit first
// - unknown opcode ignored until next select fall
// - clock level at select fall picks mode 0/3
package serial_mem_pkg;
	localparam int ADDR_W = 16;
	localparam int MEM_DEPTH = 65536;
	localparam int BYTE_W = 8;
	localparam logic [7:0] OPC_WREN = 8'h06;
	localparam logic [7:0] OPC_WRDI = 8'h04;
	localparam logic [7:0] OPC_RDSR = 8'h05;
	localparam logic [7:0] OPC_WRSR = 8'h01;
	localparam logic [7:0] OPC_READ = 8'h03;
	localparam logic [7:0] OPC_WRITE = 8'h02;
	localparam int ST_PROTECT_BIT = 7;
	localparam int ST_WEL_BIT = 1;
	localparam logic [7:0] ST_WRITABLE_MASK = 8'h8c;
	localparam logic [7:0] ST_RESET = 8'h00;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [5:0] FRAME_BITS_SHORT = 6'h08;
	localparam logic [5:0] FRAME_BITS_STATUS = 6'h10;
	localparam logic [5:0] FRAME_BITS_MEM = 6'h20;
	localparam longint SCK_MAX_HZ = 40_000_000;
	localparam longint CORE_HZ = 20_000_000;
	typedef enum {PH_OPCODE, PH_ADDR, PH_MEM_WR, PH_MEM_RD, PH_ST_RD, PH_ST_WR,
		PH_IGNORE} phase_e;
endpackage

// ===== logic/spi_link_if.sv
`timescale 1ns/1ps
interface spi_link_if;
	logic csN;
	logic sck;
	logic mosi;
	logic misoOut;
	logic misoOe;
	logic holdN;
	logic wpN;
	logic miso;
	// an undriven line reads high, as with a bus pull-up
	assign miso = misoOe ? misoOut : 1'b1;
	modport dev(input csN, input sck, input mosi, input holdN, input wpN,
		output misoOut, output misoOe);
	modport host(output csN, output sck, output mosi, output holdN, output wpN,
		input miso);
endinterface

// ===== logic/serial_mem_host.sv
`timescale 1ns/1ps
module serial_mem_host
	import serial_mem_pkg::*;
#(
	parameter int HALF_CYC = 2
)
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wrData,
	input wire logic holdReq,
	input wire logic wpLow,
	output logic busy,
	output logic done,
	output logic [7:0] rdData,
	spi_link_if.host link
);

	// sck = core / (2*HALF_CYC); the 8-bit phase counter caps HALF_CYC at 256
	if (HALF_CYC < 2 || HALF_CYC > 256 ||
		CORE_HZ / (2 * HALF_CYC) > SCK_MAX_HZ) begin : g_bad_half
		$error("HALF_CYC out of range");
	end

	typedef enum {H_IDLE, H_SHIFT, H_FINISH} hstate_e;

	typedef struct packed {
		hstate_e st;
		logic [7:0] cnt;
		logic sckLvl;
		logic [5:0] bitsLeft;
		logic [31:0] shOut;
		logic [7:0] shIn;
		logic csN;
		logic holdN;
		logic wpN;
		logic done;
		logic [7:0] rdData;
		logic misoS1;
		logic misoS2;
	} host_s;

	host_s s_r;
	host_s s_nxt;
	logic phaseEnd;
	logic linkStep;

	assign phaseEnd = (s_r.cnt == 8'(HALF_CYC - 1));
	assign linkStep = s_r.holdN && phaseEnd && (s_r.st != H_IDLE);

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.misoS1 = link.miso;
		s_nxt.misoS2 = s_r.misoS1;
		s_nxt.wpN = ~wpLow;
		// never move hold on an edge that also moves the clock or select
		if (!s_r.sckLvl && !linkStep && !(s_r.st == H_IDLE && start)) begin
			s_nxt.holdN = ~holdReq;
		end
		case (s_r.st)
			H_IDLE: begin
				if (start) begin
					s_nxt.csN = 1'b0;
					s_nxt.shOut = {opcode, addr, wrData};
					s_nxt.cnt = 8'h00;
					if (opcode == OPC_READ || opcode == OPC_WRITE) begin
						s_nxt.bitsLeft = FRAME_BITS_MEM;
					end else if (opcode == OPC_RDSR || opcode == OPC_WRSR) begin
						s_nxt.bitsLeft = FRAME_BITS_STATUS;
						s_nxt.shOut = {opcode, wrData, 16'h0000};
					end else begin
						s_nxt.bitsLeft = FRAME_BITS_SHORT;
					end
					s_nxt.st = H_SHIFT;
				end
			end
			H_SHIFT: begin
				if (s_r.holdN) begin
					s_nxt.cnt = phaseEnd ? 8'h00 : s_r.cnt + 8'h01;
					if (phaseEnd && !s_r.sckLvl) begin
						s_nxt.sckLvl = 1'b1;
					end else if (phaseEnd) begin
						s_nxt.sckLvl = 1'b0;
						s_nxt.shIn = {s_r.shIn[6:0], s_r.misoS2};
						s_nxt.shOut = {s_r.shOut[30:0], 1'b0};
						s_nxt.bitsLeft = s_r.bitsLeft - 6'h01;
						if (s_r.bitsLeft == 6'h01) begin
							s_nxt.st = H_FINISH;
						end
					end
				end
			end
			H_FINISH: begin
				s_nxt.cnt = s_r.holdN ? s_r.cnt + 8'h01 : s_r.cnt;
				if (phaseEnd && s_r.holdN) begin
					s_nxt.csN = 1'b1;
					s_nxt.done = 1'b1;
					s_nxt.rdData = s_r.shIn;
					s_nxt.cnt = 8'h00;
					s_nxt.st = H_IDLE;
				end
			end
			default: begin
				s_nxt.st = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_r <= '{st: H_IDLE, cnt: 8'h00, sckLvl: 1'b0, bitsLeft: 6'h00,
				shOut: 32'h00000000, shIn: 8'h00, csN: 1'b1, holdN: 1'b1, wpN: 1'b1,
				done: 1'b0, rdData: 8'h00, misoS1: 1'b1, misoS2: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign link.csN = s_r.csN;
	assign link.sck = s_r.sckLvl;
	assign link.mosi = s_r.shOut[31];
	assign link.holdN = s_r.holdN;
	assign link.wpN = s_r.wpN;
	assign busy = (s_r.st != H_IDLE);
	assign done = s_r.done;
	assign rdData = s_r.rdData;

endmodule

// ===== verification/serial_mem_props.sv
`timescale 1ns/1ps
module serial_mem_props (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic csN,
	input wire logic sck,
	input wire logic mosi,
	input wire logic misoOut,
	input wire logic misoOe,
	input wire logic holdN
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	logic [5:0] rises_r;
	// oversampled on the core clock: the host derives the link clock from it
	always_ff @(posedge core_clk) begin
		if (srst || csN)
			rises_r <= 6'h00;
		else if ($rose(sck))
			rises_r <= rises_r + 6'h01;
	end
	sequence s_frame_end;
		$rose(csN);
	endsequence
	a_frame_bits: assert property (s_frame_end |-> rises_r inside {6'h08, 6'h10, 6'h20})
		else $error("frame bit count");
	a_idle_tristate: assert property (csN && holdN |-> !misoOe)
		else $error("output driven while idle");
	a_hold_tristate: assert property (!holdN |-> !misoOe)
		else $error("output driven in hold");
	a_miso_on_fall: assert property (misoOe && $past(misoOe) && $changed(misoOut) |-> $fell(sck))
		else $error("output moved off falling edge");
	a_mosi_steady: assert property ($rose(sck) |-> $stable(mosi))
		else $error("input moved at rising edge");
	a_hold_edge: assert property ($changed(holdN) |-> !sck && !$past(sck))
		else $error("hold moved with clock high");
	a_hold_freeze: assert property (!holdN |-> $stable(sck) && $stable(csN))
		else $error("link moved during hold");
	a_sck_in_frame: assert property ($rose(sck) |-> !csN)
		else $error("clock without select");
	a_sck_idle_low: assert property (csN |-> !sck)
		else $error("clock high while idle");
endmodule

// ===== verification/tb_serial_memory_spi_slave_port.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module tb_serial_memory_spi_slave_port
	import serial_mem_pkg::*;
;
	typedef struct {logic [7:0] op; logic [15:0] a; logic [7:0] d; logic [7:0] e;} row_s;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic porRst = 1'b1;
	logic start = 1'b0;
	logic [7:0] opcode = 8'h00;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wrData = 8'h00;
	logic holdReq = 1'b0;
	logic wpLow = 1'b0;
	logic busy, done, clkMode3, selected;
	logic [7:0] rdData, statusWord;
	int n_mismatch = 0;
	int checks = 0;
	// undriven output reads ff, so writes also prove the line stayed released
	row_s rows [8] = '{'{OPC_WREN, 16'h0000, 8'h00, 8'hff},
		'{OPC_WRITE, 16'h0000, 8'ha5, 8'hff}, '{OPC_WRITE, 16'hffff, 8'h3c, 8'hff},
		'{OPC_READ, 16'h0000, 8'h00, 8'ha5}, '{OPC_READ, 16'hffff, 8'h00, 8'h3c},
		'{OPC_WRSR, 16'h0000, 8'h8c, 8'hff}, '{OPC_RDSR, 16'h0000, 8'h00, 8'h8c},
		'{OPC_WRDI, 16'h0000, 8'h00, 8'hff}};
	spi_link_if link();
	serial_mem_host serial_mem_host_i (.core_clk(core_clk), .srst(srst), .start(start),
		.opcode(opcode), .addr(addr), .wrData(wrData), .holdReq(holdReq), .wpLow(wpLow),
		.busy(busy), .done(done), .rdData(rdData), .link(link));
	serial_mem_device serial_mem_device_i (.link(link), .porRst(porRst),
		.clkMode3(clkMode3), .selected(selected), .statusWord(statusWord));
	serial_mem_props serial_mem_props_i (.core_clk(core_clk), .srst(srst), .csN(link.csN),
		.sck(link.sck), .mosi(link.mosi), .misoOut(link.misoOut), .misoOe(link.misoOe),
		.holdN(link.holdN));
	always #25 core_clk = ~core_clk;
	task automatic xfer(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d);
		int n;
		@(negedge core_clk);
		start = 1'b1;
		opcode = op;
		addr = a;
		wrData = d;
		@(negedge core_clk);
		start = 1'b0;
		for (n = 0; n < 400 && done !== 1'b1; n++) begin
			@(posedge core_clk);
			#1;
		end
		`CHK(done, 1'b1)
	endtask
	task automatic print_verdict();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#2000000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		repeat (10) @(negedge core_clk);
		srst = 1'b0;
		porRst = 1'b0;
		foreach (rows[i]) begin
			xfer(rows[i].op, rows[i].a, rows[i].d);
			`CHK(rdData, rows[i].e)
		end
		`CHK(clkMode3, 1'b0)
		$display("test rows done");
		@(negedge core_clk);
		wpLow = 1'b1;
		xfer(OPC_WREN, 16'h0000, 8'h00);
		xfer(OPC_WRSR, 16'h0000, 8'h00);
		`CHK(statusWord, 8'h8c)
		@(negedge core_clk);
		wpLow = 1'b0;
		xfer(OPC_WRSR, 16'h0000, 8'h00);
		`CHK(statusWord, 8'h00)
		$display("test protect done");
		xfer(OPC_WRDI, 16'h0000, 8'h00);
		xfer(OPC_WRITE, 16'h0000, 8'h11);
		xfer(8'h0b, 16'h0000, 8'h00);
		`CHK(rdData, 8'hff)
		xfer(OPC_READ, 16'h0000, 8'h00);
		`CHK(rdData, 8'ha5)
		$display("test refusal done");
		fork
			xfer(OPC_READ, 16'hffff, 8'h00);
			begin
				repeat (110) @(negedge core_clk);
				`CHK(link.misoOe, 1'b1)
				holdReq = 1'b1;
				repeat (30) @(negedge core_clk);
				`CHK({selected, busy, link.misoOe}, 3'h6)
				holdReq = 1'b0;
			end
		join
		`CHK(rdData, 8'h3c)
		$display("test hold done");
		@(negedge core_clk);
		srst = 1'b1;
		@(negedge core_clk);
		srst = 1'b0;
		`CHK({link.csN, busy, rdData}, 10'h200)
		xfer(OPC_READ, 16'h0000, 8'h00);
		`CHK(rdData, 8'ha5)
		$display("test reset done");
		print_verdict();
	end
endmodule
